// >>> testbench/pcm_assertions.sv
// Port checker for the power and clock manager
`default_nettype none
module pcm_checker (
    input wire logic        i_clock,
    input wire logic        i_rst,
    input wire logic        i_battery_domain_reset_pin,
    input wire logic        i_interrupt,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        o_battery_domain_reset,
    input wire logic        o_osc_enable,
    input wire logic        o_osc_bypass,
    input wire logic        o_pll_enable,
    input wire logic [5:0]  o_pll_multiplier,
    input wire logic        o_pll_bypass,
    input wire logic [1:0]  o_clock_source_select,
    input wire logic [2:0]  o_prescale_shift,
    input wire logic        o_core_clock_enable,
    input wire logic        o_irq_osc_stable,
    input wire logic        o_irq_pll_lock
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    sequence core_woken;
        ##[1:3] o_core_clock_enable;
    endsequence
    bkrst_hold_a: assert property (
        !i_battery_domain_reset_pin [*4] |=> o_battery_domain_reset)
        else $error("battery reset dropped while pin low");
    idle_wake_a: assert property (
        !o_core_clock_enable && i_interrupt |-> core_woken)
        else $error("core clock not resumed on interrupt");
    osc_off_a: assert property (
        $fell(o_osc_enable) && !o_osc_bypass |-> !o_irq_osc_stable)
        else $error("stable request kept after oscillator off");
    bypass_osc_a: assert property (o_osc_bypass |-> !o_osc_enable)
        else $error("oscillator running while bypassed");
    mul_zero_a: assert property (o_pll_multiplier == 6'h00 |-> !o_pll_enable)
        else $error("pll enabled with zero multiplier");
    lock_bypass_a: assert property (o_irq_pll_lock |-> !o_pll_bypass)
        else $error("pll bypassed while locked");
    pll_source_a: assert property (o_clock_source_select == 2'h2 |-> o_pll_enable)
        else $error("pll selected but disabled");
    legal_source_a: assert property (o_clock_source_select != 2'h3)
        else $error("reserved clock source selected");
    presc_range_a: assert property (o_prescale_shift <= 3'h6)
        else $error("prescale shift above six");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
endmodule
bind pcm_power_clock_manager pcm_checker chk (.i_clock, .i_rst, .i_battery_domain_reset_pin,
    .i_interrupt, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .o_battery_domain_reset, .o_osc_enable, .o_osc_bypass, .o_pll_enable,
    .o_pll_multiplier, .o_pll_bypass, .o_clock_source_select, .o_prescale_shift,
    .o_core_clock_enable, .o_irq_osc_stable, .o_irq_pll_lock);
`default_nettype wire

// >>> testbench/pcm_far_side.sv
// Far-side model: backup reset pin, wake-up pin, RTC alarm and interrupt source
`default_nettype none
module pcm_far_side (
    input  wire logic i_clock,
    output logic      o_battery_domain_reset_pin,
    output logic      o_interrupt,
    output logic      o_wakeup_pin,
    output logic      o_rtc_alarm
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_battery_domain_reset_pin = 1'b0;
        o_interrupt = 1'b0;
        o_wakeup_pin = 1'b0;
        o_rtc_alarm = 1'b0;
    end
    task automatic release_backup();
        o_battery_domain_reset_pin <= 1'b1;
        @(posedge i_clock);
    endtask
    task automatic raise_irq();
        o_interrupt <= 1'b1;
        repeat (2) @(posedge i_clock);
        o_interrupt <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic wake(input logic use_alarm);
        if (use_alarm) begin
            o_rtc_alarm <= 1'b1;
        end else begin
            o_wakeup_pin <= 1'b1;
        end
        repeat (3) @(posedge i_clock);
        o_rtc_alarm <= 1'b0;
        o_wakeup_pin <= 1'b0;
        repeat (5) @(posedge i_clock);
    endtask
endmodule
`default_nettype wire

// >>> testbench/test_power_clock_manager.sv
// Testbench for the power and clock manager
`default_nettype none
module test_power_clock_manager;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = pcm_pkg::SLOW_TICK_CYCLES;
    localparam logic [1:0] OK = pcm_pkg::RESP_OKAY;
    localparam logic [7:0] CG = pcm_pkg::CGMR_OFFSET;
    localparam logic [7:0] MD = pcm_pkg::MODE_OFFSET;
    localparam logic [7:0] WK = pcm_pkg::WAKE_CFG_OFFSET;
    logic        i_clock, i_rst, i_interrupt, i_wakeup_pin, i_rtc_alarm;
    logic        i_battery_domain_reset_pin, o_main_power_on, o_irq_osc_stable, o_irq_pll_lock;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, o_clock_source_select;
    logic        o_battery_domain_reset, o_osc_enable, o_osc_bypass, o_pll_enable;
    logic        o_pll_bypass, o_core_clock_enable;
    logic [5:0]  o_pll_multiplier;
    logic [2:0]  o_prescale_shift;
    int          mismatches = 0, total_checks = 0, cyc = 0, n;
    pcm_power_clock_manager uut (.i_clock, .i_rst, .i_battery_domain_reset_pin, .i_interrupt,
        .i_wakeup_pin, .i_rtc_alarm, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .o_battery_domain_reset, .o_osc_enable,
        .o_osc_bypass, .o_pll_enable, .o_pll_multiplier, .o_pll_bypass, .o_clock_source_select,
        .o_prescale_shift, .o_core_clock_enable, .o_main_power_on, .o_irq_osc_stable,
        .o_irq_pll_lock);
    pcm_far_side far (.i_clock, .o_battery_domain_reset_pin(i_battery_domain_reset_pin),
        .o_interrupt(i_interrupt), .o_wakeup_pin(i_wakeup_pin), .o_rtc_alarm(i_rtc_alarm));
    task automatic test_done();
        if (mismatches == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge i_clock);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
        repeat (2) @(posedge i_clock);
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge i_clock);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk(32'(s_axi_rresp), 32'(er));
        @(posedge i_clock);
    endtask
    task automatic wait_lock();
        n = 0;
        while (o_irq_pll_lock !== 1'b1) begin
            @(posedge i_clock);
            n++;
        end
        chk(32'(n >= T - 8 && n <= 3 * T + 16), 32'h1);
        chk(32'(o_pll_bypass), 32'h0);
    endtask
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        i_rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        repeat (6) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        axr(CG, 32'h0, OK);
        axr(pcm_pkg::STATUS_OFFSET, 32'h4, OK);
        axr(MD, 32'h2, OK);
        chk(32'(o_pll_bypass), 32'h1);
        far.release_backup();
        repeat (100) @(posedge i_clock);
        chk(32'(o_battery_domain_reset), 32'h1);
        axr(8'h14, 32'h0, pcm_pkg::RESP_SLVERR);
        axw(8'h18, 32'h1, pcm_pkg::RESP_SLVERR);
        axw(pcm_pkg::IRQ_EN_OFFSET, 32'h3, OK);
        axw(CG, 32'h0000_4000, OK);
        chk(32'(o_clock_source_select), 32'h0);
        axw(CG, 32'h000a_0072, OK);
        n = 0;
        while (o_irq_osc_stable !== 1'b1) begin
            @(posedge i_clock);
            n++;
        end
        chk(32'(n >= 60 && n <= 92), 32'h1);
        chk(32'(o_prescale_shift), 32'h6);
        axw(CG, 32'h010a_0372, OK);
        chk(32'(o_irq_osc_stable), 32'h1);
        chk(32'(o_pll_multiplier), 32'h3);
        chk(32'(o_pll_bypass), 32'h1);
        wait_lock();
        axr(pcm_pkg::STATUS_OFFSET, 32'h7, OK);
        axw(pcm_pkg::IRQ_EN_OFFSET, 32'h2, OK);
        chk(32'(o_irq_osc_stable), 32'h0);
        chk(32'(o_irq_pll_lock), 32'h1);
        axw(pcm_pkg::IRQ_EN_OFFSET, 32'h3, OK);
        axw(CG, 32'h010a_8372, OK);
        chk(32'(o_clock_source_select), 32'h2);
        axw(CG, 32'h010a_8370, OK);
        chk(32'(o_osc_enable), 32'h1);
        axw(CG, 32'h010a_8072, OK);
        chk(32'(o_pll_enable), 32'h1);
        axw(CG, 32'h010a_4372, OK);
        chk(32'(o_clock_source_select), 32'h1);
        axw(CG, 32'h010a_0372, OK);
        axw(CG, 32'h010a_0572, OK);
        chk(32'(o_irq_pll_lock), 32'h0);
        wait_lock();
        axw(CG, 32'h010a_0570, OK);
        chk(32'(o_irq_osc_stable), 32'h0);
        axw(CG, 32'h010a_0571, OK);
        chk(32'(o_osc_bypass), 32'h1);
        axw(MD, 32'h1, OK);
        chk(32'(o_core_clock_enable), 32'h0);
        far.raise_irq();
        axr(MD, 32'h0, OK);
        axw(MD, 32'h3, OK);
        chk(32'(o_core_clock_enable), 32'h0);
        far.raise_irq();
        axr(MD, 32'h2, OK);
        axw(WK, 32'h2, OK);
        axw(MD, 32'h4, OK);
        chk(32'(o_main_power_on), 32'h0);
        far.wake(1'b1);
        chk(32'(o_main_power_on), 32'h1);
        axw(WK, 32'h1, OK);
        axw(MD, 32'h4, OK);
        far.wake(1'b1);
        chk(32'(o_main_power_on), 32'h0);
        far.wake(1'b0);
        chk(32'(o_main_power_on), 32'h1);
        test_done();
    end
endmodule
`default_nettype wire

// >>> verilog/pcm_pkg.sv
// Package of constants and types for the power and clock manager
`default_nettype none
package pcm_pkg;
    localparam int        SLOW_CLOCK_HZ      = 32768;
    localparam int        CLOCK_HZ           = 100000000;
    // Slow clock tick period in system cycles, rounded down, at least one
    localparam int        SLOW_TICK_CYCLES   = (CLOCK_HZ / SLOW_CLOCK_HZ) < 1 ? 1
                                               : (CLOCK_HZ / SLOW_CLOCK_HZ);
    localparam int        BACKUP_RESET_TICKS = 32768;
    localparam int        OSC_DIVIDE         = 8;
    // Register byte offsets
    localparam logic [7:0] CGMR_OFFSET       = 8'h00;
    localparam logic [7:0] STATUS_OFFSET     = 8'h04;
    localparam logic [7:0] MODE_OFFSET       = 8'h08;
    localparam logic [7:0] IRQ_EN_OFFSET     = 8'h0c;
    localparam logic [7:0] WAKE_CFG_OFFSET   = 8'h10;
    // Clock generator mode register fields
    localparam int        CGMR_PRES_LSB      = 4;
    localparam int        CGMR_BYPASS_BIT    = 0;
    localparam int        CGMR_OSCEN_BIT     = 1;
    localparam int        CGMR_CSS_LSB       = 14;
    localparam int        CGMR_MUL_LSB       = 8;
    localparam int        CGMR_OSC_STARTUP_COUNT_LSB   = 16;
    localparam int        CGMR_PLL_STARTUP_COUNT_LSB  = 24;
    // Status register fields
    localparam int        STATUS_STABLE_BIT  = 0;
    localparam int        STATUS_LOCK_BIT    = 1;
    localparam int        STATUS_BKRST_BIT   = 2;
    localparam logic [31:0] CGMR_RESET       = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;
    localparam logic [2:0]  PRES_MAX         = 3'h6;
    typedef enum logic [1:0] {
        PCM_CSS_SLOW,
        PCM_CSS_MAIN,
        PCM_CSS_PLL,
        PCM_CSS_RSVD
    } pcm_css_t;
    typedef enum logic [2:0] {
        PCM_MODE_NORMAL,
        PCM_MODE_IDLE,
        PCM_MODE_SLOW,
        PCM_MODE_STANDBY,
        PCM_MODE_POWER_DOWN
    } pcm_mode_t;
endpackage
`default_nettype wire

// >>> verilog/pcm_power_clock_manager.sv
// Power and clock manager: modes, backup reset, oscillator, PLL and AXI4-Lite registers
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`default_nettype none
module pcm_power_clock_manager (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_battery_domain_reset_pin,
    input  wire logic        i_interrupt,
    input  wire logic        i_wakeup_pin,
    input  wire logic        i_rtc_alarm,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             o_battery_domain_reset,
    output logic             o_osc_enable,
    output logic             o_osc_bypass,
    output logic             o_pll_enable,
    output logic [5:0]       o_pll_multiplier,
    output logic             o_pll_bypass,
    output logic [1:0]       o_clock_source_select,
    output logic [2:0]       o_prescale_shift,
    output logic             o_core_clock_enable,
    output logic             o_main_power_on,
    output logic             o_irq_osc_stable,
    output logic             o_irq_pll_lock
);
    // Slow clock tick divider
    logic [15:0] slow_div;
    logic        slow_tick;
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            slow_div  <= 16'h0000;
            slow_tick <= 1'b0;
        end else if (slow_div == 16'(pcm_pkg::SLOW_TICK_CYCLES - 1)) begin
            slow_div  <= 16'h0000;
            slow_tick <= 1'b1;
        end else begin
            slow_div  <= slow_div + 16'h0001;
            slow_tick <= 1'b0;
        end
    end

    // Backup reset stretcher
    logic [15:0] bk_count;
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            bk_count               <= 16'h0000;
            o_battery_domain_reset <= 1'b1;
        end else begin
            if (!i_battery_domain_reset_pin) begin
                bk_count               <= 16'h0000;
                o_battery_domain_reset <= 1'b1;
            end else if (o_battery_domain_reset && slow_tick) begin
                if (bk_count == 16'(pcm_pkg::BACKUP_RESET_TICKS - 1)) begin
                    o_battery_domain_reset <= 1'b0;
                end else begin
                    bk_count <= bk_count + 16'h0001;
                end
            end
        end
    end

    // Bus write channel capture
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_go;
    assign wr_go = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    // Write response
    logic wr_map;
    assign wr_map = aw_addr[1:0] == 2'h0 && aw_addr <= pcm_pkg::WAKE_CFG_OFFSET;
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= pcm_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? pcm_pkg::RESP_OKAY : pcm_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Full-word write data merged with byte strobes into the mode register
    logic [31:0] cgmr;
    logic [31:0] cg_new;
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            cg_new[b*8 +: 8] = w_strb[b] ? w_data[b*8 +: 8] : cgmr[b*8 +: 8];
        end
    end
    logic cg_wr;
    assign cg_wr = wr_go && aw_addr == pcm_pkg::CGMR_OFFSET;

    logic       new_osc_en;
    logic [5:0] new_mul;
    logic [1:0] new_css;
    logic       osc_stable;
    logic       pll_lock;
    logic       css_ok;
    assign new_osc_en = cg_new[pcm_pkg::CGMR_OSCEN_BIT];
    assign new_mul    = cg_new[pcm_pkg::CGMR_MUL_LSB +: 6];
    assign new_css    = cg_new[pcm_pkg::CGMR_CSS_LSB +: 2];
    always_comb begin
        css_ok = 1'b1;
        if (new_css != 2'(pcm_pkg::PCM_CSS_SLOW) && !(osc_stable && new_osc_en)) begin
            css_ok = 1'b0;
        end
        if (new_css == 2'(pcm_pkg::PCM_CSS_PLL) && (new_mul == 6'h00 || !pll_lock)) begin
            css_ok = 1'b0;
        end
        if (new_css == 2'(pcm_pkg::PCM_CSS_RSVD)) begin
            css_ok = 1'b0;
        end
        if (o_clock_source_select == 2'(pcm_pkg::PCM_CSS_PLL) && new_mul == 6'h00) begin
            css_ok = 1'b0;
        end
        if (o_clock_source_select != 2'(pcm_pkg::PCM_CSS_SLOW) && !new_osc_en) begin
            css_ok = 1'b0;
        end
    end

    // oscillator off at reset; PLL off at reset
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cgmr <= pcm_pkg::CGMR_RESET;
        end else if (cg_wr && css_ok) begin
            cgmr <= cg_new;
        end
    end

    // slow clock after reset; oscillator follows its enable unless bypassed, PLL runs for a nonzero multiplier
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_clock_source_select <= 2'(pcm_pkg::PCM_CSS_SLOW);
            o_prescale_shift      <= 3'h0;
            o_osc_enable          <= 1'b0;
            o_osc_bypass          <= 1'b0;
            o_pll_enable          <= 1'b0;
            o_pll_multiplier      <= 6'h00;
        end else begin
            o_clock_source_select <= cgmr[pcm_pkg::CGMR_CSS_LSB +: 2];
            o_prescale_shift <= (cgmr[pcm_pkg::CGMR_PRES_LSB +: 3] > pcm_pkg::PRES_MAX)
                                ? pcm_pkg::PRES_MAX : cgmr[pcm_pkg::CGMR_PRES_LSB +: 3];
            o_osc_bypass <= cgmr[pcm_pkg::CGMR_BYPASS_BIT];
            o_osc_enable <= cgmr[pcm_pkg::CGMR_OSCEN_BIT] && !cgmr[pcm_pkg::CGMR_BYPASS_BIT];
            // ratio is multiplier plus one; zero disables
            o_pll_multiplier <= cgmr[pcm_pkg::CGMR_MUL_LSB +: 6];
            o_pll_enable     <= cgmr[pcm_pkg::CGMR_MUL_LSB +: 6] != 6'h00;
        end
    end

    // Oscillator start-up counter
    logic [7:0] osc_count;
    logic [2:0] osc_pre;
    logic       osc_run;
    logic       osc_start;
    assign osc_start = cg_wr && css_ok && new_osc_en;
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            osc_count  <= 8'h00;
            osc_pre    <= 3'h0;
            osc_run    <= 1'b0;
            osc_stable <= 1'b0;
        end else if (cg_wr && css_ok && !new_osc_en) begin
            // clear stable at once; off until recount
            osc_run    <= 1'b0;
            osc_stable <= 1'b0;
        end else if (osc_start && !cgmr[pcm_pkg::CGMR_OSCEN_BIT]) begin
            osc_count  <= cg_new[pcm_pkg::CGMR_OSC_STARTUP_COUNT_LSB +: 8];
            osc_pre    <= 3'h0;
            osc_run    <= 1'b1;
            osc_stable <= 1'b0;
        end else if (osc_run) begin
            osc_pre <= osc_pre + 3'h1;
            if (osc_count == 8'h00) begin
                osc_run    <= 1'b0;
                osc_stable <= 1'b1;
            end else if (osc_pre == 3'(pcm_pkg::OSC_DIVIDE - 1)) begin
                osc_count <= osc_count - 8'h01;
            end
        end
    end

    // PLL start-up counter
    logic [7:0] pll_count;
    logic       pll_run;
    logic       mul_change;
    assign mul_change = cg_wr && css_ok && new_mul != cgmr[pcm_pkg::CGMR_MUL_LSB +: 6];
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pll_count <= 8'h00;
            pll_run   <= 1'b0;
            pll_lock  <= 1'b0;
        end else if (mul_change) begin
            // clear lock and reload; count n gives n+1 ticks
            pll_count <= cg_new[pcm_pkg::CGMR_PLL_STARTUP_COUNT_LSB +: 8];
            pll_run   <= new_mul != 6'h00;
            pll_lock  <= 1'b0;
        end else if (pll_run && slow_tick) begin
            if (pll_count != 8'h00) begin
                pll_count <= pll_count - 8'h01;
            end else if (osc_stable || cgmr[pcm_pkg::CGMR_BYPASS_BIT]) begin
                // lock at zero; wait for oscillator too unless bypassed
                pll_run  <= 1'b0;
                pll_lock <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_pll_bypass <= 1'b1;
        end else begin
            o_pll_bypass <= !pll_lock;
        end
    end

    // Interrupt enables and wake configuration
    logic [1:0] irq_en;
    logic [1:0] wake_cfg;
    logic [2:0] mode_req;
    logic       mode_wr;
    assign mode_wr = wr_go && aw_addr == pcm_pkg::MODE_OFFSET && w_strb[0];
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            irq_en   <= 2'h0;
            wake_cfg <= 2'h0;
        end else if (wr_go && w_strb[0]) begin
            if (aw_addr == pcm_pkg::IRQ_EN_OFFSET) begin
                irq_en <= w_data[1:0];
            end
            if (aw_addr == pcm_pkg::WAKE_CFG_OFFSET) begin
                wake_cfg <= w_data[1:0];
            end
        end
    end
    assign mode_req = w_data[2:0];

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_irq_osc_stable <= 1'b0;
            o_irq_pll_lock   <= 1'b0;
        end else begin
            o_irq_osc_stable <= osc_stable && irq_en[0];
            o_irq_pll_lock   <= pll_lock && irq_en[1];
        end
    end

    // Operating mode state
    pcm_pkg::pcm_mode_t mode;
    logic               wake_q;
    logic               wake_edge;
    // Bit 0 selects rising (1) or falling (0) edge; bit 1 enables alarm wake-up
    assign wake_edge = wake_cfg[0] ? (i_wakeup_pin && !wake_q) : (!i_wakeup_pin && wake_q);
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= i_wakeup_pin;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            mode <= pcm_pkg::PCM_MODE_SLOW;
        end else begin
            unique case (mode)
                pcm_pkg::PCM_MODE_IDLE: begin
                    if (i_interrupt) begin
                        mode <= pcm_pkg::PCM_MODE_NORMAL;
                    end
                end
                pcm_pkg::PCM_MODE_STANDBY: begin
                    // standby wakes to slow clock mode
                    if (i_interrupt) begin
                        mode <= pcm_pkg::PCM_MODE_SLOW;
                    end
                end
                pcm_pkg::PCM_MODE_POWER_DOWN: begin
                    if (wake_edge || (wake_cfg[1] && i_rtc_alarm)) begin
                        mode <= pcm_pkg::PCM_MODE_SLOW;
                    end
                end
                pcm_pkg::PCM_MODE_NORMAL,
                pcm_pkg::PCM_MODE_SLOW: begin
                    if (mode_wr && mode_req <= 3'(pcm_pkg::PCM_MODE_POWER_DOWN)) begin
                        mode <= pcm_pkg::pcm_mode_t'(mode_req);
                    end
                end
                default: begin
                    mode <= pcm_pkg::PCM_MODE_SLOW;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_core_clock_enable <= 1'b1;
            o_main_power_on     <= 1'b1;
        end else begin
            o_core_clock_enable <= mode == pcm_pkg::PCM_MODE_NORMAL
                                   || mode == pcm_pkg::PCM_MODE_SLOW;
            o_main_power_on     <= mode != pcm_pkg::PCM_MODE_POWER_DOWN;
        end
    end

    // Read channel
    logic [31:0] rd_word;
    always_comb begin
        unique case (s_axi_araddr)
            pcm_pkg::CGMR_OFFSET:     rd_word = cgmr;
            pcm_pkg::STATUS_OFFSET:   rd_word = {29'h0, o_battery_domain_reset, pll_lock,
                                                 osc_stable};
            pcm_pkg::MODE_OFFSET:     rd_word = {29'h0, mode};
            pcm_pkg::IRQ_EN_OFFSET:   rd_word = {30'h0, irq_en};
            pcm_pkg::WAKE_CFG_OFFSET: rd_word = {30'h0, wake_cfg};
            default:                  rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= pcm_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= (s_axi_araddr[1:0] == 2'h0
                                 && s_axi_araddr <= pcm_pkg::WAKE_CFG_OFFSET)
                                ? pcm_pkg::RESP_OKAY : pcm_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire
